// >>> rtl/rxef_regs.svh
`ifndef RXEF_REGS_SVH
`define RXEF_REGS_SVH

// Register byte offsets on the plain register port.
`define RXEF_ADDR_W          8
`define RXEF_OFF_ERRSRC      8'h00
`define RXEF_OFF_STATE       8'h04
`define RXEF_OFF_IRQ_STATUS  8'h08
`define RXEF_OFF_IRQ_MASK    8'h0C

// Error source register fields.
`define RXEF_ERR_OVERRUN     3
`define RXEF_ERR_TIMING      2
`define RXEF_ERR_LENGTH      1
`define RXEF_ERR_PARITY      0
`define RXEF_ERRSRC_RESET    8'h00

// Receive state register fields.
`define RXEF_ST_BYTE_READY   7
`define RXEF_ST_BEGIN        2
`define RXEF_ST_DONE         1
`define RXEF_ST_ERR_END      0
`define RXEF_STATE_RESET     8'h00

// Interrupt status and mask fields.
`define RXEF_IRQ_ERR_END     0
`define RXEF_IRQ_BEGIN       1
`define RXEF_IRQ_BYTE_READY  2
`define RXEF_IRQ_WAIT        3
`define RXEF_IRQ_W           4
`define RXEF_IRQ_RESET       4'h0

`endif

// >>> rtl/rxef_pkg.sv
package rxef_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PRE,
    ST_RECV,
    ST_WAIT
  } rxef_state_t;

  typedef logic [7:0] rxef_byte_t;

endpackage

// >>> rtl/rxef_rc_flags.sv
// Bank of flags that hardware sets and software clears by writing 0 to a
// bit that an earlier read returned as 1. A set in the clearing cycle wins.
module rxef_rc_flags
  import rxef_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic [W-1:0] setVec,
  input  wire logic         rdHit,
  input  wire logic         wrHit,
  input  wire logic [W-1:0] wrData,
  output logic      [W-1:0] flags_q
);

  logic [W-1:0] armed_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // A read that saw the bit at 1 arms its clear; any write disarms.
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          armed_q[i] <= 1'b0;
        end else if (wrHit) begin
          armed_q[i] <= 1'b0;
        end else if (rdHit && flags_q[i]) begin // RULE13
          armed_q[i] <= 1'b1;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (srst) begin
          flags_q[i] <= 1'b0;
        end else if (setVec[i]) begin
          flags_q[i] <= 1'b1;
        end else if (wrHit && !wrData[i] && armed_q[i]) begin
          flags_q[i] <= 1'b0; // RULE11
        end
      end
    end
  endgenerate

endmodule

// >>> rtl/rxef_ctrl.sv
`include "rxef_regs.svh"

// Contract
// RULE1: Error sources count only after receive start was raised in this frame.
// RULE2: Errors before receive start abort to wait, setting no flags.
// RULE3: Error source register records overrun, timing, length overflow, parity.
// RULE4: Error source bits 7 to 4 read 0 and ignore writes.
// RULE5: Parity start while byte ready is set sets overrun and error end.
// RULE6: Overrun still set at acknowledge bit answers NAK.
// RULE7: Sender retransmits after NAK up to its attempt limit.
// RULE8: Each retransmitted byte gets NAK while overrun stays set.
// RULE9: After overrun clears, next byte gets ACK and is accepted.
// RULE10: Broadcast with overrun set at acknowledge goes straight to wait.
// RULE11: Software clears overrun by writing 0 after reading it as 1.
// RULE12: Error end flag clears on its own while sources remain set.
// RULE13: Writing 0 without prior read of 1, or writing 1, leaves overrun.
module rxef_ctrl
  import rxef_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     srst,
  input  wire logic [`RXEF_ADDR_W-1:0]  regAddr,
  input  wire logic [7:0]               regWrData,
  input  wire logic                     regWrStb,
  input  wire logic                     regRdStb,
  output logic      [7:0]               regRdData_q,
  input  wire logic                     frameDetEvt,
  input  wire logic                     rxBeginEvt,
  input  wire logic                     preErrEvt,
  input  wire logic                     parityStartEvt,
  input  wire logic                     ackSlotEvt,
  input  wire logic                     broadcastRx,
  input  wire logic                     timingErrEvt,
  input  wire logic                     lengthOvfEvt,
  input  wire logic                     parityErrEvt,
  input  wire logic                     frameDoneEvt,
  input  wire logic                     busIdle,
  output logic                          ackStrobe_q,
  output logic                          ackNak_q,
  output logic                          waitEnter_q,
  output logic                          irq_q
);

  rxef_state_t              stateQ;
  rxef_state_t              stateD;
  rxef_byte_t               errSrcQ;
  rxef_byte_t               rxStateQ;
  rxef_byte_t               errSrcSet;
  rxef_byte_t               rxStateSet;
  logic [`RXEF_IRQ_W-1:0]   irqStatus_q;
  logic [`RXEF_IRQ_W-1:0]   irqMask_q;
  logic [`RXEF_IRQ_W-1:0]   irqSet;
  logic                     inRecv;
  logic                     overrunNow;
  logic                     srcErr;
  logic                     ackOk;
  logic                     ackBad;
  logic                     goWait;
  logic                     hitErrSrc;
  logic                     hitState;
  logic                     hitIrqSt;
  logic                     hitMask;

  // Address decode.
  always_comb begin
    hitErrSrc = 1'b0;
    hitState  = 1'b0;
    hitIrqSt  = 1'b0;
    hitMask   = 1'b0;
    if (regAddr == `RXEF_OFF_ERRSRC) begin
      hitErrSrc = 1'b1;
    end else if (regAddr == `RXEF_OFF_STATE) begin
      hitState = 1'b1;
    end else if (regAddr == `RXEF_OFF_IRQ_STATUS) begin
      hitIrqSt = 1'b1;
    end else if (regAddr == `RXEF_OFF_IRQ_MASK) begin
      hitMask = 1'b1;
    end
  end

  // Error sources are only honoured once receive start has been seen.
  assign inRecv = (stateQ == ST_RECV); // RULE1

  assign overrunNow = inRecv && parityStartEvt && rxStateQ[`RXEF_ST_BYTE_READY]; // RULE5
  assign srcErr     = inRecv && (timingErrEvt || lengthOvfEvt || parityErrEvt);

  // The acknowledge answer samples the overrun flag as it stands in the slot,
  // so a clear that lands before the slot turns the answer into ACK.
  assign ackBad = inRecv && ackSlotEvt && errSrcQ[`RXEF_ERR_OVERRUN]; // RULE6
  assign ackOk  = inRecv && ackSlotEvt && !errSrcQ[`RXEF_ERR_OVERRUN]; // RULE9

  assign goWait = (stateQ == ST_PRE && preErrEvt)
               || srcErr
               || (ackBad && broadcastRx);

  // Error source sets; bits 7 to 4 never set, so their flops in the 8-bit bank stay 0.
  always_comb begin
    errSrcSet = 8'h00; // RULE4
    errSrcSet[`RXEF_ERR_OVERRUN] = overrunNow; // RULE3
    errSrcSet[`RXEF_ERR_TIMING]  = inRecv && timingErrEvt; // RULE3
    errSrcSet[`RXEF_ERR_LENGTH]  = inRecv && lengthOvfEvt; // RULE3
    errSrcSet[`RXEF_ERR_PARITY]  = inRecv && parityErrEvt; // RULE3
  end

  // Error end is a flag of its own, not an OR of the sources.
  always_comb begin
    rxStateSet = 8'h00;
    rxStateSet[`RXEF_ST_ERR_END]    = overrunNow || srcErr; // RULE12
    rxStateSet[`RXEF_ST_BEGIN]      = (stateQ == ST_PRE) && rxBeginEvt;
    rxStateSet[`RXEF_ST_DONE]       = inRecv && frameDoneEvt && !srcErr;
    rxStateSet[`RXEF_ST_BYTE_READY] = ackOk; // RULE9
  end

  rxef_rc_flags #(
    .W (8)
  ) u_errsrc (
    .clk_sys (clk_sys),
    .srst    (srst),
    .setVec  (errSrcSet),
    .rdHit   (regRdStb && hitErrSrc),
    .wrHit   (regWrStb && hitErrSrc),
    .wrData  (regWrData),
    .flags_q (errSrcQ)
  );

  rxef_rc_flags #(
    .W (8)
  ) u_rxstate (
    .clk_sys (clk_sys),
    .srst    (srst),
    .setVec  (rxStateSet),
    .rdHit   (regRdStb && hitState),
    .wrHit   (regWrStb && hitState),
    .wrData  (regWrData),
    .flags_q (rxStateQ)
  );

  // Frame sequencing.
  always_comb begin
    stateD = stateQ;
    case (stateQ)
      ST_IDLE: begin
        if (frameDetEvt) begin
          stateD = ST_PRE;
        end
      end
      ST_PRE: begin
        if (preErrEvt) begin
          stateD = ST_WAIT; // RULE2
        end else if (rxBeginEvt) begin
          stateD = ST_RECV;
        end
      end
      ST_RECV: begin
        if (goWait) begin
          stateD = ST_WAIT; // RULE10
        end else if (frameDoneEvt) begin
          stateD = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (busIdle) begin
          stateD = ST_IDLE;
        end
      end
      default: begin
        stateD = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stateQ <= ST_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      waitEnter_q <= 1'b0;
    end else begin
      waitEnter_q <= goWait; // RULE2
    end
  end

  // Acknowledge answer to the sending unit; NAK persists for every
  // retransmission until software resolves the overrun.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ackStrobe_q <= 1'b0;
      ackNak_q    <= 1'b0;
    end else begin
      ackStrobe_q <= ackOk || ackBad;
      if (ackOk || ackBad) begin
        ackNak_q <= ackBad; // RULE8
      end
    end
  end

  // Interrupt status: sticky, cleared by writing 1, set wins.
  always_comb begin
    irqSet = `RXEF_IRQ_RESET;
    irqSet[`RXEF_IRQ_ERR_END]    = rxStateSet[`RXEF_ST_ERR_END];
    irqSet[`RXEF_IRQ_BEGIN]      = rxStateSet[`RXEF_ST_BEGIN];
    irqSet[`RXEF_IRQ_BYTE_READY] = rxStateSet[`RXEF_ST_BYTE_READY];
    irqSet[`RXEF_IRQ_WAIT]       = goWait;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irqStatus_q <= `RXEF_IRQ_RESET;
    end else if (regWrStb && hitIrqSt) begin
      irqStatus_q <= (irqStatus_q & ~regWrData[`RXEF_IRQ_W-1:0]) | irqSet;
    end else begin
      irqStatus_q <= irqStatus_q | irqSet;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irqMask_q <= `RXEF_IRQ_RESET;
    end else if (regWrStb && hitMask) begin
      irqMask_q <= regWrData[`RXEF_IRQ_W-1:0];
    end
  end

  // One cycle late against the status bits, which keeps the output a flop.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irqStatus_q & irqMask_q);
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads 0.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      regRdData_q <= 8'h00;
    end else if (!regRdStb) begin
      regRdData_q <= 8'h00;
    end else if (hitErrSrc) begin
      regRdData_q <= {4'h0, errSrcQ[3:0]}; // RULE4
    end else if (hitState) begin
      regRdData_q <= rxStateQ;
    end else if (hitIrqSt) begin
      regRdData_q <= {4'h0, irqStatus_q};
    end else if (hitMask) begin
      regRdData_q <= {4'h0, irqMask_q};
    end else begin
      regRdData_q <= 8'h00;
    end
  end

  // Checks.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  sequence seqOvrCause;
    inRecv && parityStartEvt && rxStateQ[`RXEF_ST_BYTE_READY];
  endsequence

  sequence seqAckSlot;
    inRecv && ackSlotEvt;
  endsequence

  sequence seqReadErrEnd;
    (regRdStb && hitState) ##1 regRdData_q[`RXEF_ST_ERR_END];
  endsequence

  chk_pre_no_flags: assert property ( // RULE2
    (stateQ == ST_PRE && preErrEvt)
      |=> ((errSrcQ & ~$past(errSrcQ)) == 8'h00) && waitEnter_q && stateQ == ST_WAIT
  ) else $error("error before receive start set a flag or missed wait");

  chk_idle_no_src: assert property ( // RULE1
    (stateQ != ST_RECV && (timingErrEvt || parityErrEvt || lengthOvfEvt))
      |=> ((errSrcQ & ~$past(errSrcQ)) == 8'h00)
  ) else $error("error source recorded outside reception");

  chk_src_timing: assert property ( // RULE3
    (inRecv && timingErrEvt) |=> errSrcQ[`RXEF_ERR_TIMING] && rxStateQ[`RXEF_ST_ERR_END]
  ) else $error("timing error not recorded");

  chk_resv_zero: assert property ( // RULE4
    (regRdStb && hitErrSrc) |=> regRdData_q[7:4] == 4'h0 && errSrcQ[7:4] == 4'h0
  ) else $error("reserved error source bits not zero");

  chk_ovr_set: assert property ( // RULE5
    seqOvrCause |=> errSrcQ[`RXEF_ERR_OVERRUN] && rxStateQ[`RXEF_ST_ERR_END]
  ) else $error("overrun not flagged with error end");

  chk_nak_ovr: assert property ( // RULE6
    (seqAckSlot ##0 errSrcQ[`RXEF_ERR_OVERRUN]) |=> ackStrobe_q && ackNak_q
  ) else $error("overrun at acknowledge did not answer NAK");

  chk_ack_clear: assert property ( // RULE9
    (seqAckSlot ##0 !errSrcQ[`RXEF_ERR_OVERRUN])
      |=> ackStrobe_q && !ackNak_q && rxStateQ[`RXEF_ST_BYTE_READY]
  ) else $error("clear overrun did not answer ACK and accept");

  chk_bcast_wait: assert property ( // RULE10
    (seqAckSlot ##0 (errSrcQ[`RXEF_ERR_OVERRUN] && broadcastRx))
      |=> waitEnter_q && stateQ == ST_WAIT
  ) else $error("broadcast overrun did not enter wait");

  chk_ovr_hold: assert property ( // RULE13
    (errSrcQ[`RXEF_ERR_OVERRUN] && regWrStb && hitErrSrc && regWrData[`RXEF_ERR_OVERRUN])
      |=> errSrcQ[`RXEF_ERR_OVERRUN]
  ) else $error("writing one changed the overrun flag");

  chk_errend_indep: assert property ( // RULE12
    (seqReadErrEnd ##0 (regWrStb && hitState && !regWrData[`RXEF_ST_ERR_END]
      && errSrcQ != 8'h00 && !rxStateSet[`RXEF_ST_ERR_END]))
      |=> !rxStateQ[`RXEF_ST_ERR_END]
  ) else $error("error end not clearable while sources set");

  sequence seqRetryNak;
    seqAckSlot ##0 (errSrcQ[`RXEF_ERR_OVERRUN] && ackNak_q);
  endsequence

  chk_nak_retry: assert property ( // RULE8
    seqRetryNak |=> ackStrobe_q && ackNak_q
  ) else $error("retransmitted byte with overrun set did not get NAK");

  // Arming lives in the flag bank, so the check looks through to it.
  chk_ovr_noarm: assert property ( // RULE13
    (errSrcQ[`RXEF_ERR_OVERRUN] && !u_errsrc.armed_q[`RXEF_ERR_OVERRUN]
      && regWrStb && hitErrSrc) |=> errSrcQ[`RXEF_ERR_OVERRUN]
  ) else $error("unarmed zero write cleared the overrun flag");

  chk_begin_recv: assert property ( // RULE1
    (stateQ == ST_PRE && rxBeginEvt && !preErrEvt) |=> inRecv && rxStateQ[`RXEF_ST_BEGIN]
  ) else $error("receive start did not enter reception");

  chk_ack_quiet: assert property ( // RULE6
    !(inRecv && ackSlotEvt) |=> !ackStrobe_q
  ) else $error("acknowledge answered without a slot in reception");

endmodule

// >>> tb/rxef_tx_unit.sv
module rxef_tx_unit (
  input  wire logic clk_sys,
  input  wire logic ackStrobe_q,
  input  wire logic ackNak_q,
  output logic      frameDetEvt,
  output logic      rxBeginEvt,
  output logic      parityStartEvt,
  output logic      ackSlotEvt,
  output logic      frameDoneEvt,
  output logic      busIdle
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {frameDetEvt, rxBeginEvt, parityStartEvt, ackSlotEvt, frameDoneEvt, busIdle} = 6'h00;
  end

  task automatic startFrame(input bit withBegin);
    @(posedge clk_sys) busIdle <= 1'b1;
    @(posedge clk_sys) busIdle <= 1'b0;
    frameDetEvt <= 1'b1;
    @(posedge clk_sys) frameDetEvt <= 1'b0;
    rxBeginEvt <= withBegin;
    @(posedge clk_sys) rxBeginEvt <= 1'b0;
  endtask

  // A NAK makes the sender repeat the byte; a slot left unanswered ends the attempts.
  task automatic sendByte(input int lim, output int tries, output logic nak);
    tries = 0;
    nak = 1'b1;
    while (nak === 1'b1 && tries < lim) begin
      tries++;
      @(posedge clk_sys) parityStartEvt <= 1'b1;
      @(posedge clk_sys) parityStartEvt <= 1'b0;
      @(posedge clk_sys) ackSlotEvt <= 1'b1;
      @(posedge clk_sys) ackSlotEvt <= 1'b0;
      #1 nak = ackStrobe_q ? ackNak_q : 1'bx;
    end
  endtask

  task automatic endFrame;
    @(posedge clk_sys) frameDoneEvt <= 1'b1;
    @(posedge clk_sys) frameDoneEvt <= 1'b0;
  endtask
endmodule

// >>> tb/tb_rx_error_flag_overrun_ctrl.sv
`include "rxef_regs.svh"

module tb_rx_error_flag_overrun_ctrl;
  import rxef_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [3:0] ev;
    rxef_byte_t errs;
  } rxef_row_t;
  localparam logic [7:0] ES = `RXEF_OFF_ERRSRC;
  localparam logic [7:0] ST = `RXEF_OFF_STATE;
  localparam logic [7:0] IS = `RXEF_OFF_IRQ_STATUS;
  localparam logic [7:0] IM = `RXEF_OFF_IRQ_MASK;
  localparam int         TRIES = 3;
  localparam rxef_row_t  ROWS [3] = '{'{4'h4, 8'h04}, '{4'h2, 8'h02}, '{4'h1, 8'h01}};

  logic       clk_sys = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData_q;
  logic       regWrStb = 1'b0, regRdStb = 1'b0, broadcastRx = 1'b0;
  logic       preErrEvt = 1'b0, timingErrEvt = 1'b0, lengthOvfEvt = 1'b0, parityErrEvt = 1'b0;
  logic       frameDetEvt, rxBeginEvt, parityStartEvt, ackSlotEvt, frameDoneEvt, busIdle;
  logic       ackStrobe_q, ackNak_q, waitEnter_q, irq_q, nak;
  rxef_byte_t d;
  int         tries, error_cnt = 0, checks_done = 0;

  always #25 clk_sys = ~clk_sys;

  rxef_ctrl dut (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData_q(regRdData_q),
    .frameDetEvt(frameDetEvt), .rxBeginEvt(rxBeginEvt), .preErrEvt(preErrEvt),
    .parityStartEvt(parityStartEvt), .ackSlotEvt(ackSlotEvt), .broadcastRx(broadcastRx),
    .timingErrEvt(timingErrEvt), .lengthOvfEvt(lengthOvfEvt), .parityErrEvt(parityErrEvt),
    .frameDoneEvt(frameDoneEvt), .busIdle(busIdle), .ackStrobe_q(ackStrobe_q),
    .ackNak_q(ackNak_q), .waitEnter_q(waitEnter_q), .irq_q(irq_q));

  rxef_tx_unit p (.clk_sys(clk_sys), .ackStrobe_q(ackStrobe_q), .ackNak_q(ackNak_q),
    .frameDetEvt(frameDetEvt), .rxBeginEvt(rxBeginEvt), .parityStartEvt(parityStartEvt),
    .ackSlotEvt(ackSlotEvt), .frameDoneEvt(frameDoneEvt), .busIdle(busIdle));

  task automatic cmp(input rxef_byte_t got, input rxef_byte_t exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input rxef_byte_t v);
    @(posedge clk_sys) regAddr <= a;
    regWrData <= v;
    regWrStb <= 1'b1;
    @(posedge clk_sys) regWrStb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output rxef_byte_t v);
    @(posedge clk_sys) regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys) regRdStb <= 1'b0;
    #1 v = regRdData_q;
  endtask

  // Read followed by a write in the very next cycle, to the same address.
  task automatic rdWr(input logic [7:0] a, input rxef_byte_t w, output rxef_byte_t v);
    @(posedge clk_sys) regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys) regRdStb <= 1'b0;
    regWrData <= w;
    regWrStb <= 1'b1;
    #1 v = regRdData_q;
    @(posedge clk_sys) regWrStb <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input rxef_byte_t exp);
    rxef_byte_t v;
    rd(a, v);
    cmp(v, exp);
  endtask

  // Reads arm the clears, so each register is read before its zero write.
  task automatic clearAll;
    rd(ES, d);
    rd(ST, d);
    wr(ES, 8'h00);
    wr(ST, 8'h00);
    wr(IS, 8'h0F);
  endtask

  task automatic pulseErr(input logic [3:0] ev);
    @(posedge clk_sys) {preErrEvt, timingErrEvt, lengthOvfEvt, parityErrEvt} <= ev;
    @(posedge clk_sys) {preErrEvt, timingErrEvt, lengthOvfEvt, parityErrEvt} <= 4'h0;
    #1;
  endtask

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    rdChk(ES, 8'h00);
    rdChk(ST, 8'h00);
    rdChk(8'h10, 8'h00);
    cmpBit(irq_q, 1'b0);
    $display("test reset done");
    foreach (ROWS[i]) begin
      p.startFrame(1'b1);
      pulseErr(ROWS[i].ev);
      cmpBit(waitEnter_q, 1'b1);
      rdChk(ES, ROWS[i].errs);
      rdChk(ST, 8'h05);
      clearAll();
      rdChk(ES, 8'h00);
    end
    $display("test error sources done");
    p.startFrame(1'b0);
    pulseErr(4'h4);
    cmpBit(waitEnter_q, 1'b0);
    pulseErr(4'h8);
    cmpBit(waitEnter_q, 1'b1);
    rdChk(ES, 8'h00);
    rdChk(ST, 8'h00);
    $display("test early error done");
    wr(IM, 8'h01);
    p.startFrame(1'b1);
    p.sendByte(TRIES, tries, nak);
    cmpBit(nak, 1'b0);
    rdChk(ST, 8'h84);
    p.sendByte(TRIES, tries, nak);
    cmpBit(nak, 1'b1);
    cmp(8'(tries), 8'(TRIES));
    rdChk(ES, 8'h08);
    rdChk(ST, 8'h85);
    cmpBit(irq_q, 1'b1);
    wr(ES, 8'hF8);
    wr(ES, 8'h00);
    rdChk(ES, 8'h08);
    rdWr(ST, 8'h84, d);
    cmp(d, 8'h85);
    rdChk(ST, 8'h84);
    rdChk(ES, 8'h08);
    wr(IM, 8'h00);
    tick();
    cmpBit(irq_q, 1'b0);
    wr(IM, 8'h01);
    tick();
    cmpBit(irq_q, 1'b1);
    wr(IS, 8'h01);
    tick();
    cmpBit(irq_q, 1'b0);
    wr(ES, 8'h00);
    wr(ST, 8'h00);
    rdChk(ES, 8'h00);
    p.sendByte(TRIES, tries, nak);
    cmpBit(nak, 1'b0);
    cmp(8'(tries), 8'h01);
    rdChk(ST, 8'h80);
    p.endFrame();
    $display("test overrun done");
    clearAll();
    broadcastRx <= 1'b1;
    p.startFrame(1'b1);
    p.sendByte(1, tries, nak);
    cmpBit(nak, 1'b0);
    p.sendByte(1, tries, nak);
    cmpBit(nak, 1'b1);
    cmpBit(waitEnter_q, 1'b1);
    broadcastRx <= 1'b0;
    $display("test broadcast done");
    finish_test();
  end
endmodule
